// ===== hdl/mf_pkg.sv
// Constants, types and register map for the maintenance frame engine
package mf_pkg;
   typedef logic [16:0] idx_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
   } byte_beat_t;
   typedef enum logic [2:0] {S_RECV, S_CLASS, S_LOAD, S_EXEC, S_HOST, S_FWD} eng_state_t;
   typedef enum logic [1:0] {T_IDLE, T_HOST, T_FWD, T_CRC} tx_state_t;
   // APB register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_RUN = 8'h04;
   localparam logic [7:0] OFS_PHYS_LO = 8'h08;
   localparam logic [7:0] OFS_PHYS_HI = 8'h0C;
   localparam logic [7:0] OFS_XFER = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [47:0] PHYS_RESET = 48'h0000_0000_0000;
   localparam int MODE_LOOP = 2;
   localparam int MODE_TXCRC_DIS = 3;
   localparam int MODE_INTERNAL_LOOP_SELECT = 6;
   localparam int MODE_MAINT_DIS = 9;
   // Frame layout, byte positions
   localparam idx_t BUF_BYTES = 17'h005EE;
   localparam idx_t POS_TYPE = 17'h0000C;
   localparam idx_t POS_COUNT = 17'h0000E;
   localparam idx_t POS_CODE = 17'h00010;
   localparam idx_t POS_LOAD_ADDR = 17'h00012;
   localparam idx_t POS_IMAGE = 17'h00016;
   localparam idx_t POS_SKIP_END = 17'h00010;
   localparam idx_t MIN_FRAME = 17'h00040;
   localparam idx_t CRC_BYTES = 17'h00004;
   localparam idx_t FWD_TAIL = 17'h00008;
   localparam logic [15:0] LOAD_HDR = 16'h000A;
   localparam logic [15:0] CNT_MIN = 16'h000C;
   localparam logic [15:0] CNT_MAX = 16'h05DA;
   localparam logic [15:0] SKIP_STEP = 16'h0008;
   localparam logic [15:0] TYPE_LOAD = 16'h6001;
   localparam logic [15:0] TYPE_LOOP = 16'h9000;
   localparam logic [15:0] FUNC_REPLY = 16'h0001;
   localparam logic [15:0] FUNC_FWD = 16'h0002;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
endpackage : mf_pkg

// ===== hdl/maint_frame_engine.sv
// Maintenance frame engine: memory load, loopback modes and loop frame forwarding
// Behaviour
// [R1] Load frames recognised by dump/load type
// [R2] Server keeps count within 12..1498
// [R3] Load address starts image storage
// [R4] Image bytes written consecutively to memory
// [R5] Start execution at transfer address
// [R6] Sender pads frame to minimum length
// [R7] Loop-enable mode bit selects loopback
// [R8] Internal loop stays inside; else network
// [R9] Host builds full, acceptable loopback frame
// [R10] Host limits loopback data to 32
// [R11] CRC-disable: no append, check on receive
// [R12] CRC-enable: append, skip receive check
// [R13] External loopback disables short-frame filter
// [R14] Multicast type not examined; host checks
// [R15] Maintenance-disable discards loop frames
// [R16] Bad CRC: host if running, else drop
// [R17] Multicast loop: host if running, else drop
// [R18] Function at skip position; unknown to host
// [R19] Reply function goes to host if running
// [R20] Forward: rewrite addresses, skip+8, new CRC
// [R21] Loop frames recognised by test type
// [R22] Originator lists forward entries, then reply
// [R23] Originator pads loop frame to minimum
// [R24] Standard 32-bit Ethernet CRC, LSB first
module maint_frame_engine (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire mf_pkg::byte_beat_t net_rx_i,
   output mf_pkg::byte_beat_t net_tx_o,
   input wire mf_pkg::byte_beat_t host_tx_i,
   output logic host_tx_ready_o,
   output mf_pkg::byte_beat_t host_rx_o,
   input wire logic host_rx_ready_i,
   output logic mem_we_o,
   output logic [31:0] mem_addr_o,
   output logic [7:0] mem_data_o,
   output logic exec_start_o,
   output logic [31:0] exec_addr_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   logic [7:0] frame_buf [mf_pkg::BUF_BYTES];
   mf_pkg::eng_state_t st, next_st, class_st;
   mf_pkg::tx_state_t tx_st, next_tx_st;
   mf_pkg::byte_beat_t rx_in, emit;
   logic [15:0] mode;
   logic running;
   logic [47:0] phys;
   logic [31:0] rx_crc, tx_crc, crc_inv, load_addr;
   logic [7:0] drop_cnt, fwd_cnt, load_cnt;
   mf_pkg::idx_t wr_idx, rx_len, rd_idx, tx_idx, load_end, fpos, fpos_q;
   logic [15:0] typ, cnt, func, skip_q;
   logic int_loop, crc_good, is_loop, mcast, fwd_fits, acc, host_adv;

   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int b = 0; b < 8; b++) begin
         r = (r[0] ^ d[b]) ? ((r >> 1) ^ mf_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_byte

   function automatic logic [7:0] rd(input mf_pkg::idx_t i);
      return (i < mf_pkg::BUF_BYTES) ? frame_buf[i[10:0]] : 8'h00;
   endfunction : rd

   function automatic logic reg_known(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= mf_pkg::OFS_STAT);
   endfunction : reg_known

   // APB slave
   assign acc = psel_i && penable_i;

   // One wait state: pready rises on the second access cycle
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= acc && !pready_o;
         pslverr_o <= acc && !pready_o && !reg_known(paddr_i);
         prdata_o <= 32'h0000_0000;
         if (acc && !pready_o && !pwrite_i) begin
            case (paddr_i)
               mf_pkg::OFS_MODE: prdata_o <= {16'h0000, mode};
               mf_pkg::OFS_RUN: prdata_o <= {31'h0000_0000, running};
               mf_pkg::OFS_PHYS_LO: prdata_o <= phys[31:0];
               mf_pkg::OFS_PHYS_HI: prdata_o <= {16'h0000, phys[47:32]};
               mf_pkg::OFS_XFER: prdata_o <= exec_addr_o;
               mf_pkg::OFS_STAT: prdata_o <= {5'h00, st, load_cnt, fwd_cnt, drop_cnt};
               default: prdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // [R7] mode word write
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mode <= mf_pkg::MODE_RESET;
         running <= 1'b0;
         phys <= mf_pkg::PHYS_RESET;
      end else if (acc && pready_o && pwrite_i) begin
         case (paddr_i)
            mf_pkg::OFS_MODE: mode <= pwdata_i[15:0];
            mf_pkg::OFS_RUN: running <= pwdata_i[0];
            mf_pkg::OFS_PHYS_LO: phys[31:0] <= pwdata_i;
            mf_pkg::OFS_PHYS_HI: phys[47:32] <= pwdata_i[15:0];
            default: ;
         endcase
      end
   end

   // [R8] internal loop feeds the transmitter straight back
   assign int_loop = mode[mf_pkg::MODE_LOOP] && mode[mf_pkg::MODE_INTERNAL_LOOP_SELECT];
   assign rx_in = int_loop ? emit : net_rx_i;

   // Receive capture
   always_ff @(posedge clk_i) begin
      if (st == mf_pkg::S_RECV && rx_in.valid && wr_idx < mf_pkg::BUF_BYTES) begin
         frame_buf[wr_idx[10:0]] <= rx_in.data;
      end
   end

   // Oversize frames keep only the first buffer-full
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_idx <= '0;
         rx_len <= '0;
      end else if (st == mf_pkg::S_RECV && rx_in.valid) begin
         wr_idx <= rx_in.last ? '0 : (wr_idx == mf_pkg::BUF_BYTES ? wr_idx : wr_idx + 17'h00001);
         if (rx_in.last) begin
            rx_len <= (wr_idx == mf_pkg::BUF_BYTES) ? wr_idx : wr_idx + 17'h00001;
         end
      end
   end

   // [R24] receive CRC runs over data and FCS
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rx_crc <= mf_pkg::CRC_INIT;
      end else if (st == mf_pkg::S_RECV) begin
         if (rx_in.valid) begin
            rx_crc <= crc_byte(rx_crc, rx_in.data);
         end
      end else if (next_st == mf_pkg::S_RECV) begin
         rx_crc <= mf_pkg::CRC_INIT;
      end
   end

   // Classification
   // Buffer read via functions: a process tracks it, an assign would not
   always_comb begin
      typ = {rd(mf_pkg::POS_TYPE), rd(mf_pkg::POS_TYPE + 17'h00001)};
      cnt = {rd(mf_pkg::POS_COUNT + 17'h00001), rd(mf_pkg::POS_COUNT)};
      // [R18] function sits skip bytes past the skip field
      fpos = mf_pkg::POS_SKIP_END + {1'b0, cnt};
      func = {rd(fpos + 17'h00001), rd(fpos)};
      mcast = frame_buf[0][0];
   end
   assign fwd_fits = fpos + mf_pkg::FWD_TAIL + mf_pkg::CRC_BYTES <= rx_len;
   // [R21] loop frames by test type
   assign is_loop = typ == mf_pkg::TYPE_LOOP;
   // [R12] receive check skipped while loopback appends CRC
   assign crc_good = (rx_crc == mf_pkg::CRC_RESIDUE) ||
      (mode[mf_pkg::MODE_LOOP] && !mode[mf_pkg::MODE_TXCRC_DIS]);

   always_comb begin
      class_st = mf_pkg::S_RECV;
      // [R13] short frames kept only in loopback
      if (rx_len < mf_pkg::MIN_FRAME && !mode[mf_pkg::MODE_LOOP]) begin
         class_st = mf_pkg::S_RECV;
      // [R1] load frame, [R2] count range guarded
      end else if (typ == mf_pkg::TYPE_LOAD) begin
         if (crc_good && rd(mf_pkg::POS_CODE) == 8'h00 && cnt >= mf_pkg::CNT_MIN && cnt <= mf_pkg::CNT_MAX) begin
            class_st = mf_pkg::S_LOAD;
         end
      end else if (is_loop) begin
         // [R15] maintenance disable
         if (mode[mf_pkg::MODE_MAINT_DIS]) begin
            class_st = mf_pkg::S_RECV;
         // [R16] [R17] bad CRC or multicast
         end else if (!crc_good || mcast) begin
            class_st = running ? mf_pkg::S_HOST : mf_pkg::S_RECV;
         // [R20] forward
         end else if (func == mf_pkg::FUNC_FWD && fwd_fits) begin
            class_st = mf_pkg::S_FWD;
         // [R19] reply, [R18] unknown function
         end else begin
            class_st = running ? mf_pkg::S_HOST : mf_pkg::S_RECV;
         end
      // [R14] no type check on other frames, multicast included
      end else if (crc_good) begin
         class_st = mf_pkg::S_HOST;
      end
   end

   always_comb begin
      next_st = st;
      case (st)
         mf_pkg::S_RECV: if (rx_in.valid && rx_in.last) next_st = mf_pkg::S_CLASS;
         mf_pkg::S_CLASS: next_st = class_st;
         mf_pkg::S_LOAD: if (rd_idx == load_end) next_st = mf_pkg::S_EXEC;
         mf_pkg::S_EXEC: next_st = mf_pkg::S_RECV;
         mf_pkg::S_HOST: if (host_rx_o.valid && host_rx_ready_i && host_rx_o.last) next_st = mf_pkg::S_RECV;
         mf_pkg::S_FWD: if (tx_st == mf_pkg::T_CRC && tx_idx == 17'h00003) next_st = mf_pkg::S_RECV;
         default: next_st = mf_pkg::S_RECV;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) st <= mf_pkg::S_RECV;
      else st <= next_st;
   end

   // [R3] load address and image end captured
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         load_addr <= 32'h0000_0000;
         load_end <= '0;
         fpos_q <= '0;
         skip_q <= 16'h0000;
      end else if (st == mf_pkg::S_CLASS) begin
         load_addr <= {rd(mf_pkg::POS_LOAD_ADDR + 17'h00003), rd(mf_pkg::POS_LOAD_ADDR + 17'h00002),
            rd(mf_pkg::POS_LOAD_ADDR + 17'h00001), rd(mf_pkg::POS_LOAD_ADDR)};
         load_end <= mf_pkg::POS_IMAGE + {1'b0, cnt - mf_pkg::LOAD_HDR} - 17'h00001;
         fpos_q <= fpos;
         skip_q <= cnt + mf_pkg::SKIP_STEP;
      end
   end

   assign host_adv = !host_rx_o.valid || host_rx_ready_i;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) rd_idx <= '0;
      else if (st == mf_pkg::S_CLASS) rd_idx <= (class_st == mf_pkg::S_LOAD) ? mf_pkg::POS_IMAGE : '0;
      else if (st == mf_pkg::S_LOAD) rd_idx <= rd_idx + 17'h00001;
      else if (st == mf_pkg::S_HOST && host_adv && rd_idx < rx_len) rd_idx <= rd_idx + 17'h00001;
   end

   // [R4] image bytes stored one per cycle
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mem_we_o <= 1'b0;
         mem_addr_o <= 32'h0000_0000;
         mem_data_o <= 8'h00;
      end else begin
         mem_we_o <= st == mf_pkg::S_LOAD;
         mem_addr_o <= load_addr + 32'(rd_idx - mf_pkg::POS_IMAGE);
         mem_data_o <= rd(rd_idx);
      end
   end

   // [R5] transfer address follows the image
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         exec_start_o <= 1'b0;
         exec_addr_o <= 32'h0000_0000;
      end else begin
         exec_start_o <= st == mf_pkg::S_EXEC;
         if (st == mf_pkg::S_EXEC) begin
            exec_addr_o <= {rd(rd_idx + 17'h00003), rd(rd_idx + 17'h00002), rd(rd_idx + 17'h00001), rd(rd_idx)};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         host_rx_o <= '0;
      end else if (st == mf_pkg::S_HOST && host_adv) begin
         host_rx_o <= (rd_idx < rx_len) ? mf_pkg::byte_beat_t'{1'b1, rd(rd_idx), rd_idx == rx_len - 17'h00001} : '0;
      end else if (host_rx_ready_i) begin
         host_rx_o.valid <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         drop_cnt <= 8'h00;
         fwd_cnt <= 8'h00;
         load_cnt <= 8'h00;
      end else begin
         if (st == mf_pkg::S_CLASS && class_st == mf_pkg::S_RECV) drop_cnt <= drop_cnt + 8'h01;
         if (st == mf_pkg::S_FWD && next_st == mf_pkg::S_RECV) fwd_cnt <= fwd_cnt + 8'h01;
         if (st == mf_pkg::S_EXEC) load_cnt <= load_cnt + 8'h01;
      end
   end

   // Transmit
   // [R20] forwarded header rewritten on the fly
   function automatic logic [7:0] fwd_byte(input mf_pkg::idx_t i);
      if (i < 17'h00006) return rd(fpos_q + 17'h00002 + i);
      if (i < 17'h0000C) return phys[8 * (i[3:0] - 4'h6) +: 8];
      if (i == mf_pkg::POS_COUNT) return skip_q[7:0];
      if (i == mf_pkg::POS_COUNT + 17'h00001) return skip_q[15:8];
      return rd(i);
   endfunction : fwd_byte

   assign crc_inv = ~tx_crc;

   always_comb begin
      emit = '0;
      case (tx_st)
         // [R11] no CRC appended when disabled
         mf_pkg::T_HOST: emit = '{host_tx_i.valid && host_tx_ready_o, host_tx_i.data,
            host_tx_i.last && mode[mf_pkg::MODE_TXCRC_DIS]};
         mf_pkg::T_FWD: emit = '{1'b1, fwd_byte(tx_idx), 1'b0};
         mf_pkg::T_CRC: emit = '{1'b1, crc_inv[8 * tx_idx[1:0] +: 8], tx_idx == 17'h00003};
         default: emit = '0;
      endcase
   end

   always_comb begin
      next_tx_st = tx_st;
      case (tx_st)
         mf_pkg::T_IDLE: begin
            if (st == mf_pkg::S_FWD) next_tx_st = mf_pkg::T_FWD;
            else if (host_tx_i.valid && (!int_loop || st == mf_pkg::S_RECV)) next_tx_st = mf_pkg::T_HOST;
         end
         mf_pkg::T_HOST: begin
            if (emit.valid && host_tx_i.last) begin
               next_tx_st = mode[mf_pkg::MODE_TXCRC_DIS] ? mf_pkg::T_IDLE : mf_pkg::T_CRC;
            end
         end
         // [R20] old FCS dropped
         mf_pkg::T_FWD: if (tx_idx == rx_len - mf_pkg::CRC_BYTES - 17'h00001) next_tx_st = mf_pkg::T_CRC;
         mf_pkg::T_CRC: if (tx_idx == 17'h00003) next_tx_st = mf_pkg::T_IDLE;
         default: next_tx_st = mf_pkg::T_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_st <= mf_pkg::T_IDLE;
         tx_idx <= '0;
         host_tx_ready_o <= 1'b0;
         net_tx_o <= '0;
      end else begin
         tx_st <= next_tx_st;
         tx_idx <= (next_tx_st != tx_st) ? '0 : (emit.valid ? tx_idx + 17'h00001 : tx_idx);
         host_tx_ready_o <= next_tx_st == mf_pkg::T_HOST;
         // [R8] internal loop keeps the wire quiet
         net_tx_o <= int_loop ? '0 : emit;
      end
   end

   // [R24] transmit CRC over every sent byte except the appended CRC bytes
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || tx_st == mf_pkg::T_IDLE) tx_crc <= mf_pkg::CRC_INIT;
      else if (emit.valid && tx_st != mf_pkg::T_CRC) tx_crc <= crc_byte(tx_crc, emit.data);
   end

   // Checks
   a_apb_one_wait: assert property (acc && !pready_o |=> pready_o ##1 !pready_o) else $error("apb wait wrong");
   a_mode_takes: assert property (acc && pready_o && pwrite_i && paddr_i == mf_pkg::OFS_MODE // [R7]
      |=> mode == $past(pwdata_i[15:0])) else $error("mode write lost");
   a_internal_loop_select_quiet: assert property (int_loop && emit.valid |=> !net_tx_o.valid) else $error("wire driven"); // [R8]
   a_load_writes: assert property (st == mf_pkg::S_LOAD |=> mem_we_o) else $error("no memory write"); // [R4]
   a_exec_after: assert property ($rose(exec_start_o) |-> $past(mem_we_o, 2) && !mem_we_o) // [R5]
      else $error("exec not after image");
   a_maint_drop: assert property (st == mf_pkg::S_CLASS && is_loop && mode[mf_pkg::MODE_MAINT_DIS] // [R15]
      && (rx_len >= mf_pkg::MIN_FRAME || mode[mf_pkg::MODE_LOOP]) |=> st == mf_pkg::S_RECV) else $error("kept");
   a_badcrc_idle: assert property (st == mf_pkg::S_CLASS && is_loop && !mode[mf_pkg::MODE_MAINT_DIS] // [R16]
      && !crc_good && !running |=> st == mf_pkg::S_RECV) else $error("bad crc kept");
   a_mcast_host: assert property (st == mf_pkg::S_CLASS && is_loop && !mode[mf_pkg::MODE_MAINT_DIS] // [R17]
      && mcast && running && rx_len >= mf_pkg::MIN_FRAME |=> st == mf_pkg::S_HOST) else $error("mcast lost");
   a_crc_append: assert property (tx_st == mf_pkg::T_HOST && emit.valid && host_tx_i.last // [R12]
      && !mode[mf_pkg::MODE_TXCRC_DIS] |=> tx_st == mf_pkg::T_CRC [*4] ##1 tx_st == mf_pkg::T_IDLE)
      else $error("crc not appended");
   a_fwd_done: assert property (st == mf_pkg::S_FWD && tx_st == mf_pkg::T_CRC && tx_idx == 17'h00003 // [R20]
      |-> emit.last ##1 st == mf_pkg::S_RECV) else $error("forward end wrong");
   c_load_exec: cover property (st == mf_pkg::S_EXEC ##1 exec_start_o);
   c_forward: cover property (tx_st == mf_pkg::T_FWD ##[1:300] tx_st == mf_pkg::T_CRC);
   c_host_frame: cover property (host_rx_o.valid && host_rx_o.last && host_rx_ready_i);
endmodule : maint_frame_engine

// ===== tb/net_node_model.sv
// Remote network node and host receive sink facing the maintenance frame engine
module net_node_model (
   input wire logic clk_i,
   input wire logic slow_i,
   output mf_pkg::byte_beat_t net_rx_o,
   output logic host_rx_ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] stall = 2'h0;

   initial begin
      net_rx_o = '0;
   end

   // Slow host accepts only every other pair of cycles
   always @(posedge clk_i) begin
      stall <= stall + 2'h1;
   end
   assign host_rx_ready_o = !slow_i || stall[1];

   // reflected register, all ones at start
   function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
      logic [31:0] c;
      c = mf_pkg::CRC_INIT;
      foreach (q[i]) begin
         c = c ^ {24'h000000, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ mf_pkg::CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : crc_of

   // caller pads; bad flips one check bit
   task automatic send_frame(input logic [7:0] q[$], input bit bad);
      logic [31:0] fcs;
      fcs = ~crc_of(q);
      for (int i = 0; i < 4; i++) q.push_back(fcs[8*i +: 8] ^ ((bad && i == 0) ? 8'h01 : 8'h00));
      foreach (q[i]) begin
         @(posedge clk_i);
         net_rx_o <= {1'b1, q[i], i == q.size() - 1};
      end
      @(posedge clk_i);
      // Released line must not keep the last byte
      net_rx_o <= {1'b0, ~q[q.size() - 1], 1'b0};
   endtask : send_frame
endmodule : net_node_model

// ===== tb/maint_loop_and_load_frames_test.sv
// Self-checking bench for the maintenance frame engine
module maint_loop_and_load_frames_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [47:0] PHYS = 48'h6655_4433_2202;
   localparam logic [47:0] SRC = 48'h0A09_0807_0604;
   localparam logic [47:0] MC = 48'h0000_0000_5E01;
   localparam logic [47:0] FWD = 48'h5A4B_3C2D_1E0C;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, mem_addr, exec_addr, rd, ex_a;
   logic pready, pslverr, host_tx_ready, host_rx_ready, mem_we, exec_start, er;
   logic slow = 1'b0;
   logic [7:0] mem_data;
   mf_pkg::byte_beat_t net_rx, net_tx, host_rx;
   mf_pkg::byte_beat_t host_tx = '0;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int n_exec = 0;
   logic [7:0] fr[$], tx_q[$], rx_q[$];
   logic [39:0] mem_q[$];

   always #50 clk_i = ~clk_i;

   maint_frame_engine u_maint_frame_engine (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .net_rx_i(net_rx), .net_tx_o(net_tx), .host_tx_i(host_tx),
      .host_tx_ready_o(host_tx_ready), .host_rx_o(host_rx), .host_rx_ready_i(host_rx_ready), .mem_we_o(mem_we),
      .mem_addr_o(mem_addr), .mem_data_o(mem_data), .exec_start_o(exec_start), .exec_addr_o(exec_addr));
   net_node_model u_net_node_model (.clk_i(clk_i), .slow_i(slow), .net_rx_o(net_rx),
      .host_rx_ready_o(host_rx_ready));

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (net_tx.valid === 1'b1) tx_q.push_back(net_tx.data);
      if (host_rx.valid === 1'b1 && host_rx_ready) rx_q.push_back(host_rx.data);
      if (mem_we === 1'b1) mem_q.push_back({mem_addr, mem_data});
      if (exec_start === 1'b1) begin
         n_exec <= n_exec + 1;
         ex_a <= exec_addr;
      end
      if (cyc == 20000) begin
         n_fail++;
         wrap_up;
      end
   end

   task wrap_up;
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task chk(input logic [63:0] exp, input logic [63:0] got, input string what);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // Request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk_i);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         t++;
      end while (pready !== 1'b1 && t < 20);
      rd = prdata;
      er = pslverr;
      if (t >= 20) chk(1, 0, "apb answer");
      {psel, penable} <= 2'b00;
   endtask : apb

   // Waits for net_tx, host_rx and mem_we to go quiet, bounded
   task settle;
      int q, t;
      q = 0;
      t = 0;
      while (q < 40 && t < 4000) begin
         @(posedge clk_i);
         t++;
         q = (net_tx.valid || host_rx.valid || mem_we) ? 0 : q + 1;
      end
   endtask : settle

   task hdr(input logic [47:0] dst, input logic [15:0] typ);
      fr.delete();
      tx_q.delete();
      rx_q.delete();
      mem_q.delete();
      n_exec = 0;
      for (int i = 0; i < 6; i++) fr.push_back(dst[8*i +: 8]);
      for (int i = 0; i < 6; i++) fr.push_back(SRC[8*i +: 8]);
      fr.push_back(typ[15:8]);
      fr.push_back(typ[7:0]);
   endtask : hdr

   task pad(input int n);
      while (fr.size() < n) fr.push_back(8'h00);
   endtask : pad

   task host_send;
      int i;
      i = 0;
      @(posedge clk_i);
      host_tx <= {1'b1, fr[0], fr.size() == 1};
      while (i < fr.size()) begin
         @(posedge clk_i);
         if (host_tx_ready === 1'b1) begin
            i++;
            if (i < fr.size()) host_tx <= {1'b1, fr[i], i == fr.size() - 1};
            else host_tx <= '0;
         end
      end
      settle;
   endtask : host_send

   task t_regs;
      apb(0, mf_pkg::OFS_MODE, 0); chk(mf_pkg::MODE_RESET, rd, "mode reset");
      apb(0, mf_pkg::OFS_RUN, 0); chk(0, rd, "run reset");
      apb(1, 8'h18, 32'hFFFF); chk(1, er, "unmapped error");
      apb(0, 8'h02, 0); chk(1, er, "misaligned error");
      apb(1, mf_pkg::OFS_PHYS_LO, PHYS[31:0]);
      apb(1, mf_pkg::OFS_PHYS_HI, {16'h0000, PHYS[47:32]});
      apb(0, mf_pkg::OFS_PHYS_HI, 0); chk({16'h0000, PHYS[47:32]}, rd, "phys hi");
      apb(1, mf_pkg::OFS_XFER, 32'h1234_5678);
      apb(0, mf_pkg::OFS_XFER, 0); chk(0, rd, "xfer read only");
   endtask : t_regs

   task t_load;
      hdr(PHYS, mf_pkg::TYPE_LOAD);
      // count 12 is the minimum, two image bytes
      fr = {fr, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h30, 8'h12, 8'h00, 8'h00, 8'hA5, 8'h5A, 8'h60, 8'h45, 8'h00, 8'h00};
      pad(60);
      u_net_node_model.send_frame(fr, 0);
      settle;
      chk(2, mem_q.size(), "image writes");
      chk({32'h1230, 8'hA5}, mem_q[0], "first write");
      chk({32'h1231, 8'h5A}, mem_q[1], "second write");
      chk(1, n_exec, "exec pulses");
      chk(32'h4560, ex_a, "exec address");
      apb(0, mf_pkg::OFS_XFER, 0); chk(32'h4560, rd, "xfer register");
   endtask : t_load

   task loop_case(input logic [47:0] dst, input logic [15:0] fn, input bit bad, input logic run,
         input logic [15:0] mode, input bit exp);
      apb(1, mf_pkg::OFS_RUN, {31'h0, run});
      apb(1, mf_pkg::OFS_MODE, {16'h0000, mode});
      hdr(dst, mf_pkg::TYPE_LOOP);
      fr = {fr, 8'h00, 8'h00, fn[7:0], fn[15:8]};
      pad(60);
      u_net_node_model.send_frame(fr, bad);
      settle;
      chk(exp, rx_q.size() >= 60, "host delivery");
      chk(0, tx_q.size(), "no transmit");
   endtask : loop_case

   task t_loop;
      loop_case(PHYS, mf_pkg::FUNC_REPLY, 0, 1, 16'h0000, 1);
      loop_case(PHYS, mf_pkg::FUNC_REPLY, 0, 0, 16'h0000, 0);
      loop_case(PHYS, mf_pkg::FUNC_REPLY, 0, 1, 16'h0200, 0);
      loop_case(PHYS, mf_pkg::FUNC_FWD, 1, 1, 16'h0000, 1);
      loop_case(PHYS, mf_pkg::FUNC_FWD, 1, 0, 16'h0000, 0);
      loop_case(MC, mf_pkg::FUNC_FWD, 0, 1, 16'h0000, 1);
      loop_case(MC, mf_pkg::FUNC_FWD, 0, 0, 16'h0000, 0);
      loop_case(PHYS, 16'h0003, 0, 1, 16'h0000, 1);
      loop_case(PHYS, 16'h0003, 0, 0, 16'h0000, 0);
   endtask : t_loop

   task t_fwd(input logic [7:0] skip);
      slow <= 1'b1;
      apb(1, mf_pkg::OFS_RUN, 32'h1);
      hdr(PHYS, mf_pkg::TYPE_LOOP);
      // one forward entry, then the reply entry
      fr = {fr, skip, 8'h00, 8'h02, 8'h00};
      for (int i = 0; i < 6; i++) fr.push_back(FWD[8*i +: 8]);
      fr = {fr, 8'h01, 8'h00};
      pad(60);
      u_net_node_model.send_frame(fr, 0);
      settle;
      slow <= 1'b0;
      if (skip == 8'h00) begin
         chk(64, tx_q.size(), "forward length");
         for (int i = 0; i < 6; i++) chk({FWD[8*i +: 8], PHYS[8*i +: 8]}, {tx_q[i], tx_q[6+i]}, "rewrite");
         chk(16'h0800, {tx_q[14], tx_q[15]}, "skip plus 8");
         chk(mf_pkg::CRC_RESIDUE, u_net_node_model.crc_of(tx_q), "forward crc");
      end else begin
         chk(0, tx_q.size(), "reply no transmit");
         chk(1, rx_q.size() >= 60, "reply to host");
      end
   endtask : t_fwd

   task t_lback(input logic [15:0] mode, input int txn);
      logic [31:0] c;
      apb(1, mf_pkg::OFS_MODE, {16'h0000, mode});
      // full frame, data field at most 32
      hdr(PHYS, 16'h0800);
      pad(mode[3] ? 42 : 46);
      c = ~u_net_node_model.crc_of(fr);
      if (mode[3]) fr = {fr, c[7:0], c[15:8], c[23:16], c[31:24]};
      host_send;
      chk(txn, tx_q.size(), "loopback transmit length");
      if (txn > 0) chk(mf_pkg::CRC_RESIDUE, u_net_node_model.crc_of(tx_q), "loopback crc");
      else chk(1, rx_q.size() > 0, "internal loop to host");
   endtask : t_lback

   task t_runt(input logic [15:0] mode, input bit exp);
      apb(1, mf_pkg::OFS_MODE, {16'h0000, mode});
      hdr(PHYS, 16'h0800);
      pad(40);
      u_net_node_model.send_frame(fr, 0);
      settle;
      chk(exp, rx_q.size() > 0, "short frame");
   endtask : t_runt

   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_regs;
      t_load;
      t_loop;
      t_fwd(8'h00);
      t_fwd(8'h08);
      t_lback(16'h0004, 50);
      t_lback(16'h000C, 46);
      t_lback(16'h0044, 0);
      t_runt(16'h0000, 0);
      t_runt(16'h0004, 1);
      wrap_up;
   end
endmodule : maint_loop_and_load_frames_test
